// ===== gpio_function_clock_out_pkg.sv
// Constants shared by the pin function and clock output block.
// Summary of operation
// [R01] Logic code: drive level, or take input
// [R02] Codes 02h/03h drive request line state
// [R03] Code 04h system clock, 3Dh async clock
// [R04] Codes 05h/06h route locked loop clocks
// [R05] Codes 08h/09h modulators; 00h no function
// [R06] Shutdown status drives 1 when shutdown done
// [R07] Level reads debounced input, ignoring inversion
// [R08] Debounced input edges both raise events
// [R09] Edge event bits latch until cleared
// [R10] Software should enable debounce on buttons
// [R11] Level field reads back input, not stored
// [R12] Invert bit flips the driven pin level
// [R13] First request line always on interrupt pin
// [R14] Two request lines, each source maskable
// [R15] System clock output enable bit 15
// [R16] Five-bit divider; 0 and 1 divide by one
// [R17] Source select picks one of four rates
// [R18] 44.1k family swaps in the lower rates
// [R19] Software keeps source rate below clock rate
// [R20] Async output register with same layout
// [R21] Async family follows async sample rate
// [R22] Software disables output before changing divider
// [R23] Disabled output low, restarts cleanly
`default_nettype none
package gpio_function_clock_out_pkg;
   // Register indices; byte address is four times the index.
   localparam logic [9:0] IDX_SYS_CLKOUT   = 10'h149;
   localparam logic [9:0] IDX_ASYNC_CLKOUT = 10'h14a;
   localparam logic [9:0] IDX_PIN_CFG_BASE = 10'h100;
   localparam logic [9:0] IDX_EVENT_STATUS = 10'h110;
   localparam logic [9:0] IDX_MASK_FIRST   = 10'h111;
   localparam logic [9:0] IDX_MASK_SECOND  = 10'h112;

   // Clock output control fields.
   localparam int CLK_EN_BIT   = 15;
   localparam int CLK_DIV_LSB  = 3;
   localparam int CLK_SEL_LSB  = 0;
   localparam logic [15:0] CLK_CTL_RESET = 16'h0000;

   // Pin configuration fields.
   localparam int PIN_DIR_BIT  = 15;
   localparam int PIN_INV_BIT  = 14;
   localparam int PIN_DEB_BIT  = 13;
   localparam int PIN_LVL_BIT  = 12;
   localparam int PIN_FN_LSB   = 0;
   localparam logic [15:0] PIN_CFG_MASK  = 16'hf07f;
   localparam logic [15:0] PIN_CFG_RESET = 16'h8001;

   // Pin function codes.
   localparam logic [6:0] FN_NONE     = 7'h00;
   localparam logic [6:0] FN_LOGIC    = 7'h01;
   localparam logic [6:0] FN_REQ1     = 7'h02;
   localparam logic [6:0] FN_REQ2     = 7'h03;
   localparam logic [6:0] FN_SYS_CLK  = 7'h04;
   localparam logic [6:0] FN_LL1      = 7'h05;
   localparam logic [6:0] FN_LL2      = 7'h06;
   localparam logic [6:0] FN_PM1      = 7'h08;
   localparam logic [6:0] FN_PM2      = 7'h09;
   localparam logic [6:0] FN_ASYNC    = 7'h3d;
   localparam logic [6:0] FN_SPK_DOWN = 7'h61;

   // Sample rate field pattern 01XXX marks the 44.1 kHz family.
   localparam logic [1:0] FAMILY_44K_TOP = 2'b01;

   localparam int DEBOUNCE_CYCLES = 16;
   localparam int NUM_PINS        = 5;
endpackage
`default_nettype wire

// ===== gpio_function_clock_out.sv
// Pin function multiplexer, input debounce, edge events, clock outputs.
//
// Decided for this implementation: the APB register port.
`default_nettype none
module gpio_function_clock_out
   import gpio_function_clock_out_pkg::*;
#(
   parameter int PINS     = NUM_PINS,
   parameter int DEBOUNCE = DEBOUNCE_CYCLES
) (
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic [11:0]     paddr,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [31:0]     pwdata,
   output var  logic [31:0]     prdata,
   output var  logic            pready,
   output var  logic            pslverr,
   input  wire logic [PINS-1:0] pin_in,
   output var  logic [PINS-1:0] pin_out,
   output var  logic [PINS-1:0] pin_oe_n,
   output var  logic            interrupt_pin,
   input  wire logic            first_locked_loop_clk,
   input  wire logic            second_locked_loop_clk,
   input  wire logic            first_pulse_modulator,
   input  wire logic            second_pulse_modulator,
   input  wire logic            speaker_shutdown_done,
   input  wire logic [4:0]      sys_sample_rate,
   input  wire logic [4:0]      async_sample_rate,
   input  wire logic [3:0]      sys_tick_48k,
   input  wire logic [3:0]      sys_tick_44k,
   input  wire logic [3:0]      async_tick_48k,
   input  wire logic [3:0]      async_tick_44k
);
   localparam int DW = $clog2(DEBOUNCE + 1);
   localparam logic [DW-1:0] DEB_LAST = DW'(DEBOUNCE);

   typedef struct packed {
      logic [PINS-1:0][15:0]   cfg;
      logic [PINS-1:0]         deb;
      logic [PINS-1:0][DW-1:0] deb_cnt;
      logic [PINS-1:0]         status;
      logic [PINS-1:0]         mask1;
      logic [PINS-1:0]         mask2;
      logic [15:0]             sys_ctl;
      logic [15:0]             async_ctl;
      logic [4:0]              sys_cnt;
      logic                    sys_clk;
      logic [4:0]              async_cnt;
      logic                    async_clk;
      logic                    req1;
      logic                    req2;
      logic                    primed;
      logic                    irq_pin;
      logic [PINS-1:0]         pin_out;
      logic [PINS-1:0]         pin_oe_n;
      logic [31:0]             prdata;
      logic                    pready;
      logic                    pslverr;
   } state_t;

   state_t s_q;
   state_t s_d;

   // Picks the source tick for a select code; reserved codes give none.
   function automatic logic pick_tick(input logic [2:0] sel,
                                      input logic [4:0] rate,
                                      input logic [3:0] t48,
                                      input logic [3:0] t44);
      logic fam44;
      fam44 = (rate[4:3] == FAMILY_44K_TOP); // [R18] [R21]
      if (sel[2]) begin
         return 1'b0; // [R17]
      end
      return fam44 ? t44[sel[1:0]] : t48[sel[1:0]]; // [R17]
   endfunction

   // One divider step: returns the next count and output level.
   function automatic logic [5:0] div_step(input logic [15:0] ctl,
                                           input logic       tick,
                                           input logic [4:0] cnt,
                                           input logic       clk);
      logic [4:0] n;
      logic [4:0] div;
      div = ctl[CLK_DIV_LSB +: 5];
      n = (div <= 5'h01) ? 5'h01 : div; // [R16]
      if (!ctl[CLK_EN_BIT]) begin
         return 6'h00; // [R15] [R23]
      end
      if (!tick) begin
         return {cnt, clk};
      end
      if (cnt + 5'h01 >= n) begin
         return {5'h00, ~clk}; // [R16]
      end
      return {cnt + 5'h01, clk};
   endfunction

   logic [9:0]  idx;
   logic        setup;
   logic        wr;
   logic [5:0]  sys_step;
   logic [5:0]  async_step;
   logic        sys_tick;
   logic        async_tick;

   assign idx   = paddr[11:2];
   assign setup = psel & ~penable;
   assign wr    = psel & penable & pwrite & s_q.pready;

   always_comb begin
      logic [PINS-1:0] edges;
      logic [PINS-1:0] clr;
      logic [6:0]      fn;
      logic            drive;
      logic            val;
      logic            hit;
      logic [31:0]     rd;
      edges = '0;
      clr   = '0;
      fn    = FN_NONE;
      drive = 1'b0;
      val   = 1'b0;
      hit   = 1'b0;
      rd    = 32'h0000_0000;
      s_d   = s_q;

      // Register writes take effect at the access edge.
      if (wr) begin
         if (idx == IDX_SYS_CLKOUT) begin
            s_d.sys_ctl = pwdata[15:0] & 16'h80ff; // [R15] [R16]
         end
         if (idx == IDX_ASYNC_CLKOUT) begin
            s_d.async_ctl = pwdata[15:0] & 16'h80ff; // [R20]
         end
         if (idx == IDX_EVENT_STATUS) begin
            clr = pwdata[PINS-1:0];
         end
         if (idx == IDX_MASK_FIRST) begin
            s_d.mask1 = pwdata[PINS-1:0]; // [R14]
         end
         if (idx == IDX_MASK_SECOND) begin
            s_d.mask2 = pwdata[PINS-1:0]; // [R14]
         end
      end

      for (int i = 0; i < PINS; i++) begin
         if (wr && idx == IDX_PIN_CFG_BASE + 10'(i)) begin
            s_d.cfg[i] = pwdata[15:0] & PIN_CFG_MASK; // [R11]
         end
         // Debounce: a new level must stand for DEBOUNCE cycles.
         if (!s_q.cfg[i][PIN_DEB_BIT]) begin
            s_d.deb[i]     = pin_in[i];
            s_d.deb_cnt[i] = '0;
         end else if (pin_in[i] == s_q.deb[i]) begin
            s_d.deb_cnt[i] = '0;
         end else if (s_q.deb_cnt[i] >= DEB_LAST - DW'(1)) begin
            s_d.deb[i]     = pin_in[i];
            s_d.deb_cnt[i] = '0;
         end else begin
            s_d.deb_cnt[i] = s_q.deb_cnt[i] + DW'(1);
         end
         // No event in the first cycle after reset, when the debounced
         // level first takes up a pin that may idle high.
         edges[i] = s_q.primed & (s_d.deb[i] ^ s_q.deb[i]); // [R08]
      end

      // Set wins over a clear in the same cycle.
      s_d.status = (s_q.status & ~clr) | edges; // [R09]
      s_d.req1 = |(s_d.status & ~s_d.mask1); // [R14]
      s_d.req2 = |(s_d.status & ~s_d.mask2); // [R14]
      s_d.irq_pin = s_d.req1; // [R13]
      s_d.primed = 1'b1;

      {s_d.sys_cnt, s_d.sys_clk} =
         div_step(s_q.sys_ctl, sys_tick, s_q.sys_cnt, s_q.sys_clk);
      {s_d.async_cnt, s_d.async_clk} =
         div_step(s_q.async_ctl, async_tick, s_q.async_cnt, s_q.async_clk);

      // Pin multiplexer.
      for (int i = 0; i < PINS; i++) begin
         fn    = s_q.cfg[i][PIN_FN_LSB +: 7];
         drive = 1'b1;
         val   = 1'b0;
         case (fn)
            FN_LOGIC: begin
               drive = ~s_q.cfg[i][PIN_DIR_BIT]; // [R01]
               val   = s_q.cfg[i][PIN_LVL_BIT]; // [R01]
            end
            FN_REQ1:     val = s_q.req1; // [R02]
            FN_REQ2:     val = s_q.req2; // [R02]
            FN_SYS_CLK:  val = s_q.sys_clk; // [R03]
            FN_ASYNC:    val = s_q.async_clk; // [R03]
            FN_LL1:      val = first_locked_loop_clk; // [R04]
            FN_LL2:      val = second_locked_loop_clk; // [R04]
            FN_PM1:      val = first_pulse_modulator; // [R05]
            FN_PM2:      val = second_pulse_modulator; // [R05]
            FN_SPK_DOWN: val = speaker_shutdown_done; // [R06]
            default:     drive = 1'b0; // [R05]
         endcase
         s_d.pin_out[i]  = drive & (val ^ s_q.cfg[i][PIN_INV_BIT]); // [R12]
         s_d.pin_oe_n[i] = ~drive;
      end

      // Read data is prepared in the setup cycle; one access cycle.
      if (idx == IDX_SYS_CLKOUT) begin
         rd  = {16'h0000, s_q.sys_ctl};
         hit = 1'b1;
      end
      if (idx == IDX_ASYNC_CLKOUT) begin
         rd  = {16'h0000, s_q.async_ctl};
         hit = 1'b1;
      end
      if (idx == IDX_EVENT_STATUS) begin
         rd  = 32'(s_q.status); // [R09]
         hit = 1'b1;
      end
      if (idx == IDX_MASK_FIRST) begin
         rd  = 32'(s_q.mask1);
         hit = 1'b1;
      end
      if (idx == IDX_MASK_SECOND) begin
         rd  = 32'(s_q.mask2);
         hit = 1'b1;
      end
      for (int i = 0; i < PINS; i++) begin
         if (idx == IDX_PIN_CFG_BASE + 10'(i)) begin
            rd = {16'h0000, s_q.cfg[i]};
            rd[PIN_LVL_BIT] = s_q.deb[i]; // [R07] [R11]
            hit = 1'b1;
         end
      end
      s_d.pready  = setup;
      s_d.prdata  = (setup && !pwrite && hit) ? rd : 32'h0000_0000;
      s_d.pslverr = setup & ~hit;
   end

   assign sys_tick = pick_tick(s_q.sys_ctl[CLK_SEL_LSB +: 3],
                               sys_sample_rate, sys_tick_48k, sys_tick_44k);
   assign async_tick = pick_tick(s_q.async_ctl[CLK_SEL_LSB +: 3],
                                 async_sample_rate, async_tick_48k,
                                 async_tick_44k);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q           <= '0;
         s_q.cfg       <= {PINS{PIN_CFG_RESET}};
         s_q.sys_ctl   <= CLK_CTL_RESET;
         s_q.async_ctl <= CLK_CTL_RESET;
         s_q.mask1     <= '1;
         s_q.mask2     <= '1;
         s_q.pin_oe_n  <= '1;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata        = s_q.prdata;
   assign pready        = s_q.pready;
   assign pslverr       = s_q.pslverr;
   assign pin_out       = s_q.pin_out;
   assign pin_oe_n      = s_q.pin_oe_n;
   assign interrupt_pin = s_q.irq_pin;
endmodule // gpio_function_clock_out
`default_nettype wire

// ===== gpio_function_clock_out_assertions.sv
// Checker on the APB answer and the pin drive of the pin block.
`default_nettype none
module gpio_function_clock_out_assertions
   import gpio_function_clock_out_pkg::*;
#(parameter int PINS = NUM_PINS) (
   input wire logic            pclk,
   input wire logic            presetn,
   input wire logic [11:0]     paddr,
   input wire logic            psel,
   input wire logic            penable,
   input wire logic [31:0]     prdata,
   input wire logic            pready,
   input wire logic            pslverr,
   input wire logic [PINS-1:0] pin_out,
   input wire logic [PINS-1:0] pin_oe_n,
   input wire logic            interrupt_pin
);
   wire logic [9:0] ix  = paddr[11:2];
   wire logic       su  = psel && !penable;
   wire logic       ck  = ix == IDX_SYS_CLKOUT || ix == IDX_ASYNC_CLKOUT;
   wire logic       hit = ck || ix - IDX_PIN_CFG_BASE < 10'(PINS)
      || ix - IDX_EVENT_STATUS < 10'h3;
   wire logic       miss = !ck && ix - IDX_PIN_CFG_BASE > 10'h12;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   AST_READY_ONE: assert property (su |=> pready ##1 !pready)
      else $error("pready not a one cycle answer");
   AST_READY_CAUSE: assert property (pready |-> $past(su))
      else $error("pready without setup");
   AST_ERR_MISS: assert property (su && miss |=> pslverr)
      else $error("unmapped access not refused");
   AST_ERR_HIT: assert property (su && hit |=> !pslverr)
      else $error("mapped access refused");
   AST_DATA_WIDTH: assert property (pready |-> prdata[31:16] == 16'h0)
      else $error("upper read data not zero");
   AST_DATA_IDLE: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   AST_UNDRIVEN: assert property ((pin_out & pin_oe_n) == '0)
      else $error("released pin shows a level");
   AST_IRQ_RESET: assert property ($rose(presetn) |-> !interrupt_pin)
      else $error("request line up after reset");
   COV_REFUSED: cover property (pready && pslverr);
   COV_REQUEST: cover property ($rose(interrupt_pin));
   COV_DRIVE: cover property ($fell(pin_oe_n[0]));
endmodule // gpio_function_clock_out_assertions
bind gpio_function_clock_out gpio_function_clock_out_assertions
   #(.PINS(PINS)) chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
   .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
   .interrupt_pin(interrupt_pin));
`default_nettype wire

// ===== pin_partner.sv
// Far side model: buttons on the pin wires and source rate ticks.
`default_nettype none
module pin_partner (
   input  wire logic       pclk,
   input  wire logic [4:0] btn,
   input  wire logic [4:0] pin_out,
   input  wire logic [4:0] pin_oe_n,
   output wire logic [4:0] pin_in,
   output var  logic [3:0] st48,
   output var  logic [3:0] st44,
   output var  logic [3:0] at48,
   output var  logic [3:0] at44
);
   int cnt = 0;
   // A driven pin shows the block's level, a released one the button.
   assign pin_in = (pin_out & ~pin_oe_n) | (btn & pin_oe_n);
   always @(posedge pclk) cnt <= cnt + 1;
   // Every select code ticks with its own period so a wrong pick shows.
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         st48[k] = cnt % (4 + k) == 0;
         st44[k] = cnt % (8 + k) == 0;
         at48[k] = cnt % (5 + k) == 0;
         at44[k] = cnt % (9 + k) == 0;
      end
   end
endmodule // pin_partner
`default_nettype wire

// ===== test_gpio_function_clock_out.sv
// Bench: register access, pin routing, edge events and clock outputs.
`default_nettype none
module test_gpio_function_clock_out
   import gpio_function_clock_out_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        interrupt_pin, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [4:0]  src, btn, pin_in, pin_out, pin_oe_n, srate;
   logic [3:0]  st48, st44, at48, at44;
   int          n_mismatch, checks_done;
   localparam logic [6:0]  FNS [5] = '{FN_LL1, FN_LL2, FN_PM1, FN_PM2,
                                       FN_SPK_DOWN};
   localparam logic [11:0] EVT = {IDX_EVENT_STATUS, 2'b00};
   localparam logic [11:0] MK1 = {IDX_MASK_FIRST, 2'b00};
   localparam logic [11:0] MK2 = {IDX_MASK_SECOND, 2'b00};
   localparam logic [11:0] SYS = {IDX_SYS_CLKOUT, 2'b00};
   localparam logic [11:0] ASY = {IDX_ASYNC_CLKOUT, 2'b00};
   gpio_function_clock_out #(.DEBOUNCE(2)) dut (.pclk(pclk),
      .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .interrupt_pin(interrupt_pin),
      .first_locked_loop_clk(src[0]), .second_locked_loop_clk(src[1]),
      .first_pulse_modulator(src[2]), .second_pulse_modulator(src[3]),
      .speaker_shutdown_done(src[4]), .sys_sample_rate(srate),
      .async_sample_rate(srate), .sys_tick_48k(st48), .sys_tick_44k(st44),
      .async_tick_48k(at48), .async_tick_44k(at44));
   pin_partner pp (.pclk(pclk), .btn(btn), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .pin_in(pin_in), .st48(st48), .st44(st44),
      .at48(at48), .at44(at44));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   task automatic wrap_up();
      if (n_mismatch == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmp(input string w, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int i;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (i >= 20) begin
         n_mismatch++;
         wrap_up();
      end
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      // A written setting reaches the registered pins one edge later.
      @(posedge pclk);
   endtask
   task automatic rdc(input string w, input logic [11:0] a,
                      input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      cmp(w, e, rd);
   endtask
   function automatic logic [31:0] cw(input logic [3:0] t,
                                       input logic [6:0] f);
      return {16'h0, t, 5'h0, f};
   endfunction
   function automatic logic [11:0] pa(input int n);
      return {IDX_PIN_CFG_BASE + 10'(n), 2'b00};
   endfunction
   // Measures the cycles between two rising edges on pin 0.
   task automatic per(input logic [11:0] a, input logic [15:0] c,
                      input logic [6:0] f, input logic [4:0] r, input int e);
      int n, s, t;
      logic q;
      q = 1'b1;
      srate <= r;
      wr(a, {16'h0, c & 16'h7fff});
      wr(pa(0), cw(4'h0, f));
      wr(a, {16'h0, c});
      for (int i = 0; i < 900 && n < 2; i++) begin
         @(posedge pclk);
         if (pin_out[0] === 1'b1 && q === 1'b0) begin
            n++;
            t = i - s;
            s = i;
         end
         q = pin_out[0];
      end
      if (n < 2)
         t = 0;
      cmp("clk period", e, t);
   endtask
   initial begin
      {presetn, psel, penable, pwrite, src, btn, srate} = '0;
      paddr  = '0;
      pwdata = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc("cfg0", pa(0), {16'h0, PIN_CFG_RESET});
      rdc("sysctl", SYS, {16'h0, CLK_CTL_RESET});
      rdc("asyncctl", ASY, 32'h0);
      apb(1'b0, 12'h600, 32'h0);
      cmp("refused", 32'h1, {31'h0, err});
      wr(pa(0), cw(4'b0001, FN_LOGIC));
      cmp("drive", 32'h1, {30'h0, pin_oe_n[0], pin_out[0]});
      wr(pa(0), cw(4'b0101, FN_LOGIC));
      cmp("inverted", 32'h0, {31'h0, pin_out[0]});
      rdc("level", pa(0), cw(4'b0100, FN_LOGIC));
      foreach (FNS[i]) begin
         wr(pa(1), cw(4'h0, FNS[i]));
         src <= 5'(1 << i);
         repeat (3) @(posedge pclk);
         cmp("route1", 32'h1, {31'h0, pin_out[1]});
         src <= 5'h0;
         repeat (3) @(posedge pclk);
         cmp("route0", 32'h0, {30'h0, pin_oe_n[1], pin_out[1]});
      end
      wr(pa(1), cw(4'h0, FN_NONE));
      cmp("nofn", 32'h1, {31'h0, pin_oe_n[1]});
      wr(pa(2), cw(4'b1010, FN_LOGIC));
      wr(EVT, 32'h1f);
      btn <= 5'h04;
      @(posedge pclk);
      btn <= 5'h00;
      repeat (6) @(posedge pclk);
      apb(1'b0, EVT, 32'h0);
      cmp("glitch", 32'h0, rd & 32'h4);
      btn <= 5'h04;
      repeat (8) @(posedge pclk);
      wr(pa(2), cw(4'b1110, FN_LOGIC));
      rdc("deblevel", pa(2), cw(4'b1111, FN_LOGIC));
      wr(EVT, 32'h1b);
      wr(MK1, 32'h1b);
      wr(pa(3), cw(4'h0, FN_REQ2));
      wr(pa(4), cw(4'h0, FN_REQ1));
      cmp("irqpin", 32'h5, {29'h0, pin_out[4:3], interrupt_pin});
      wr(MK2, 32'h1b);
      cmp("second_interrupt_request", 32'h3, {30'h0, pin_out[4:3]});
      wr(EVT, 32'h4);
      cmp("cleared", 32'h0, {29'h0, pin_out[4:3], interrupt_pin});
      btn <= 5'h00;
      repeat (8) @(posedge pclk);
      cmp("fall", 32'h1, {31'h0, interrupt_pin});
      repeat (5) @(posedge pclk);
      // Pins 3 and 4 loop back through the partner, so they latch too.
      rdc("latched", EVT, 32'h1c);
      wr(MK1, 32'h1f);
      cmp("masked", 32'h0, {31'h0, interrupt_pin});
      per(SYS, 16'h8000, FN_SYS_CLK, 5'h00, 2 * 1 * 4);
      per(SYS, 16'h8008, FN_SYS_CLK, 5'h00, 2 * 1 * 4);
      per(SYS, 16'h8019, FN_SYS_CLK, 5'h00, 2 * 3 * 5);
      per(SYS, 16'h8010, FN_SYS_CLK, 5'h08, 2 * 2 * 8);
      per(SYS, 16'h801c, FN_SYS_CLK, 5'h00, 0);
      per(SYS, 16'h0019, FN_SYS_CLK, 5'h00, 0);
      cmp("clk low", 32'h0, {31'h0, pin_out[0]});
      per(ASY, 16'h800a, FN_ASYNC, 5'h00, 2 * 1 * 7);
      per(ASY, 16'h8013, FN_ASYNC, 5'h08, 2 * 2 * 12);
      wrap_up();
   end
endmodule // test_gpio_function_clock_out
`default_nettype wire
